/* File: adcs_defines.svh */
/*
  Register offsets, field positions, reset values and phase counts of the
  conversion sequencer. Included by bare name; definitions only.
*/
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH

`define ADCS_OFS_CTRL0 6'h00
`define ADCS_OFS_CTRL1 6'h04
`define ADCS_OFS_CTRL2 6'h08
`define ADCS_OFS_RES_HI 6'h0C
`define ADCS_OFS_RES_LO 6'h10
`define ADCS_OFS_IRQ_STAT 6'h14
`define ADCS_OFS_IRQ_CLR 6'h18
`define ADCS_OFS_IRQ_EN 6'h1C

`define ADCS_C0_START 0
`define ADCS_C0_POWER 1
`define ADCS_C0_BUSY 2
`define ADCS_C0_CH_LSB 4
`define ADCS_C1_DIV_LSB 0
`define ADCS_C1_FMT 3
`define ADCS_C1_SRC_LSB 4
`define ADCS_C2_REF_LSB 0
`define ADCS_C2_GIE 4
`define ADCS_IRQ_DONE 0

`define ADCS_RST_CTRL0 8'h00
`define ADCS_RST_CTRL1 8'h00
`define ADCS_RST_CTRL2 8'h00

`define ADCS_SAMPLE_TICKS 4'h4
`define ADCS_CONVERT_TICKS 4'hC

`endif

/* File: adcs_pkg.sv */
/*
  Types shared by the conversion sequencer files.
  Assumes nothing of its surroundings.
*/
package adcs_pkg;

  typedef enum logic [1:0] {
    ADCS_IDLE = 2'b00,
    ADCS_SAMPLE = 2'b01,
    ADCS_CONVERT = 2'b10
  } adcs_state_t;

  typedef enum logic [2:0] {
    ADCS_INT_NONE = 3'b000,
    ADCS_INT_VDD = 3'b001,
    ADCS_INT_VDD_2 = 3'b010,
    ADCS_INT_VDD_4 = 3'b011,
    ADCS_INT_PGA = 3'b100,
    ADCS_INT_PGA_2 = 3'b101,
    ADCS_INT_PGA_4 = 3'b110,
    ADCS_INT_VSS = 3'b111
  } adcs_int_src_t;

  typedef struct packed {
    logic [2:0] conv_clk_div_sel;
    logic result_format_sel;
    logic [3:0] input_source_sel;
    logic [3:0] ext_channel_sel;
    logic [1:0] reference_sel;
    logic conv_power_en;
    logic global_irq_en;
  } adcs_cfg_t;

  typedef struct packed {
    logic ext_connect;
    logic [3:0] ext_channel;
    adcs_int_src_t int_src;
    logic [1:0] reference;
  } adcs_mux_t;

endpackage

/* File: adcs_clk_div.sv */
/*
  Converter clock divider: one-cycle tick every 1..128 system clocks.
  Assumes run is low between conversions so each one starts aligned.
*/
`timescale 1ns/100ps
module adcs_clk_div (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Control
  input wire logic run,
  input wire logic [2:0] div_sel,
  // Tick
  output logic tick
);

  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic [6:0] last;

  always_comb begin
    last = 7'((8'h01 << div_sel) - 8'h01);
    tick = run && (cnt_r == last);
    if (!run || tick) begin
      cnt_nxt = 7'h00;
    end else begin
      cnt_nxt = cnt_r + 7'h01;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

/* File: adcs_sequencer.sv */
/*
  Conversion sequencer around a 12-bit converter core: Avalon-MM register
  slave, start detection, sample and convert phases, input and reference
  selection, result formatting and completion interrupt.
  Assumes the core holds core_result stable from the end of the convert
  phase request until core_convert falls; it is synchronised anyway.
*/
// How it works
// - 4 sample ticks then 12 convert ticks
// - Start bit low-high-low begins a conversion
// - Busy high during conversion, low after
// - Result readable from two byte registers
// - Conversion runs alone; bus stays free
// - Result is 12 bits; full scale FFF
// - Source 0000, 0100, 11xx: external channel
// - Internal sources disconnect the external path
// - Power bit low turns converter off
// - Format bit arranges result across bytes
// - Reference field chooses converter reference
// - Interrupt needs global and converter enables
// - Divider codes 000-111 give /1 to /128
// - Conversion end sets interrupt request flag
// - Busy set once start pulse is accepted
`timescale 1ns/100ps
`include "adcs_defines.svh"
module adcs_sequencer (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Converter core
  input wire logic [11:0] core_result,
  output logic core_power_en,
  output logic core_sample,
  output logic core_convert,
  output adcs_pkg::adcs_mux_t core_mux,
  // Interrupt
  output logic irq
);

  // Bus slave
  logic wait_r;
  logic wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wr_take;
  logic req_new;

  // Configuration
  adcs_pkg::adcs_cfg_t cfg_r;
  adcs_pkg::adcs_cfg_t cfg_nxt;
  logic start_r;
  logic start_nxt;

  // Sequencer
  adcs_pkg::adcs_state_t state_r;
  adcs_pkg::adcs_state_t state_nxt;
  logic [3:0] tick_cnt_r;
  logic [3:0] tick_cnt_nxt;
  logic busy_r;
  logic busy_nxt;
  logic [11:0] result_r;
  logic [11:0] result_nxt;
  logic conv_tick;
  logic div_run;
  logic start_go;
  logic start_abort;
  logic conv_done;

  // Core result synchroniser
  logic [11:0] res_s1_r;
  logic [11:0] res_s2_r;

  // Interrupt
  logic irq_stat_r;
  logic irq_stat_nxt;
  logic irq_en_r;
  logic irq_en_nxt;
  logic irq_r;
  logic irq_nxt;

  // Core outputs
  logic power_r;
  logic sample_r;
  logic convert_r;
  adcs_pkg::adcs_mux_t mux_r;
  adcs_pkg::adcs_mux_t mux_nxt;

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;
  assign core_power_en = power_r;
  assign core_sample = sample_r;
  assign core_convert = convert_r;
  assign core_mux = mux_r;
  assign irq = irq_r;

  // Divider counts only while a conversion runs so ticks start aligned
  assign div_run = (state_r != adcs_pkg::ADCS_IDLE);

  adcs_clk_div u_div (
    .mclk(mclk),
    .nrst(nrst),
    .run(div_run),
    .div_sel(cfg_r.conv_clk_div_sel),
    .tick(conv_tick)
  );

  // One wait cycle per request, then the transfer completes
  always_comb begin
    req_new = (avs_read || avs_write) && wait_r;
    wait_nxt = !req_new;
    wr_take = avs_write && !wait_r;
    rdata_nxt = rdata_r;
    if (req_new && avs_read) begin
      rdata_nxt = 32'h0000_0000;
      unique case (avs_address)
        `ADCS_OFS_CTRL0: begin
          rdata_nxt[`ADCS_C0_START] = start_r;
          rdata_nxt[`ADCS_C0_POWER] = cfg_r.conv_power_en;
          rdata_nxt[`ADCS_C0_BUSY] = busy_r;
          rdata_nxt[`ADCS_C0_CH_LSB +: 4] = cfg_r.ext_channel_sel;
        end
        `ADCS_OFS_CTRL1: begin
          rdata_nxt[`ADCS_C1_DIV_LSB +: 3] = cfg_r.conv_clk_div_sel;
          rdata_nxt[`ADCS_C1_FMT] = cfg_r.result_format_sel;
          rdata_nxt[`ADCS_C1_SRC_LSB +: 4] = cfg_r.input_source_sel;
        end
        `ADCS_OFS_CTRL2: begin
          rdata_nxt[`ADCS_C2_REF_LSB +: 2] = cfg_r.reference_sel;
          rdata_nxt[`ADCS_C2_GIE] = cfg_r.global_irq_en;
        end
        `ADCS_OFS_RES_HI: begin
          if (cfg_r.result_format_sel) begin
            rdata_nxt[7:0] = {4'h0, result_r[11:8]};
          end else begin
            rdata_nxt[7:0] = result_r[11:4];
          end
        end
        `ADCS_OFS_RES_LO: begin
          if (cfg_r.result_format_sel) begin
            rdata_nxt[7:0] = result_r[7:0];
          end else begin
            rdata_nxt[7:0] = {result_r[3:0], 4'h0};
          end
        end
        `ADCS_OFS_IRQ_STAT: begin
          rdata_nxt[`ADCS_IRQ_DONE] = irq_stat_r;
        end
        `ADCS_OFS_IRQ_EN: begin
          rdata_nxt[`ADCS_IRQ_DONE] = irq_en_r;
        end
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Register writes
  always_comb begin
    cfg_nxt = cfg_r;
    start_nxt = start_r;
    irq_en_nxt = irq_en_r;
    if (wr_take) begin
      unique case (avs_address)
        `ADCS_OFS_CTRL0: begin
          start_nxt = avs_writedata[`ADCS_C0_START];
          cfg_nxt.conv_power_en = avs_writedata[`ADCS_C0_POWER];
          cfg_nxt.ext_channel_sel = avs_writedata[`ADCS_C0_CH_LSB +: 4];
        end
        `ADCS_OFS_CTRL1: begin
          cfg_nxt.conv_clk_div_sel = avs_writedata[`ADCS_C1_DIV_LSB +: 3];
          cfg_nxt.result_format_sel = avs_writedata[`ADCS_C1_FMT];
          cfg_nxt.input_source_sel = avs_writedata[`ADCS_C1_SRC_LSB +: 4];
        end
        `ADCS_OFS_CTRL2: begin
          cfg_nxt.reference_sel = avs_writedata[`ADCS_C2_REF_LSB +: 2];
          cfg_nxt.global_irq_en = avs_writedata[`ADCS_C2_GIE];
        end
        `ADCS_OFS_IRQ_EN: begin
          irq_en_nxt = avs_writedata[`ADCS_IRQ_DONE];
        end
        default: begin
          cfg_nxt = cfg_r;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= '0;
      start_r <= 1'b0;
      irq_en_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      start_r <= start_nxt;
      irq_en_r <= irq_en_nxt;
    end
  end

  // Result word crosses from the analogue core through two flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      res_s1_r <= 12'h000;
      res_s2_r <= 12'h000;
    end else begin
      res_s1_r <= core_result;
      res_s2_r <= res_s1_r;
    end
  end

  // Sequencer: rising start resets, falling start launches
  always_comb begin
    start_abort = start_nxt && !start_r;
    start_go = !start_nxt && start_r && cfg_r.conv_power_en;
    conv_done = 1'b0;
    state_nxt = state_r;
    tick_cnt_nxt = tick_cnt_r;
    busy_nxt = busy_r;
    result_nxt = result_r;
    // The sequence needs no bus traffic once launched
    unique case (state_r)
      adcs_pkg::ADCS_IDLE: begin
        if (start_go) begin
          state_nxt = adcs_pkg::ADCS_SAMPLE;
          tick_cnt_nxt = 4'h0;
          busy_nxt = 1'b1;
        end
      end
      adcs_pkg::ADCS_SAMPLE: begin
        if (conv_tick) begin
          if (tick_cnt_r == `ADCS_SAMPLE_TICKS - 4'h1) begin
            state_nxt = adcs_pkg::ADCS_CONVERT;
            tick_cnt_nxt = 4'h0;
          end else begin
            tick_cnt_nxt = tick_cnt_r + 4'h1;
          end
        end
      end
      adcs_pkg::ADCS_CONVERT: begin
        if (conv_tick) begin
          if (tick_cnt_r == `ADCS_CONVERT_TICKS - 4'h1) begin
            state_nxt = adcs_pkg::ADCS_IDLE;
            tick_cnt_nxt = 4'h0;
            busy_nxt = 1'b0;
            result_nxt = res_s2_r;
            conv_done = 1'b1;
          end else begin
            tick_cnt_nxt = tick_cnt_r + 4'h1;
          end
        end
      end
      default: begin
        state_nxt = adcs_pkg::ADCS_IDLE;
      end
    endcase
    // Power off or a fresh start edge abandons the running conversion
    if (!cfg_nxt.conv_power_en || start_abort) begin
      state_nxt = adcs_pkg::ADCS_IDLE;
      tick_cnt_nxt = 4'h0;
      busy_nxt = 1'b0;
      result_nxt = result_r;
      conv_done = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= adcs_pkg::ADCS_IDLE;
      tick_cnt_r <= 4'h0;
      busy_r <= 1'b0;
      result_r <= 12'h000;
    end else begin
      state_r <= state_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      busy_r <= busy_nxt;
      result_r <= result_nxt;
    end
  end

  // Interrupt: a completion in the clearing cycle still sets the flag
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (wr_take && (avs_address == `ADCS_OFS_IRQ_CLR) &&
        avs_writedata[`ADCS_IRQ_DONE]) begin
      irq_stat_nxt = 1'b0;
    end
    if (conv_done) begin
      irq_stat_nxt = 1'b1;
    end
    irq_nxt = irq_stat_nxt && irq_en_nxt && cfg_nxt.global_irq_en;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Input path and reference decode
  always_comb begin
    mux_nxt.ext_channel = cfg_nxt.ext_channel_sel;
    mux_nxt.reference = cfg_nxt.reference_sel;
    mux_nxt.ext_connect = 1'b0;
    mux_nxt.int_src = adcs_pkg::ADCS_INT_NONE;
    unique casez (cfg_nxt.input_source_sel)
      4'b0000, 4'b0100, 4'b11??: begin
        mux_nxt.ext_connect = 1'b1;
      end
      4'b0001: begin
        mux_nxt.int_src = adcs_pkg::ADCS_INT_VDD;
      end
      4'b0010: begin
        mux_nxt.int_src = adcs_pkg::ADCS_INT_VDD_2;
      end
      4'b0011: begin
        mux_nxt.int_src = adcs_pkg::ADCS_INT_VDD_4;
      end
      4'b0101: begin
        mux_nxt.int_src = adcs_pkg::ADCS_INT_PGA;
      end
      4'b0110: begin
        mux_nxt.int_src = adcs_pkg::ADCS_INT_PGA_2;
      end
      4'b0111: begin
        mux_nxt.int_src = adcs_pkg::ADCS_INT_PGA_4;
      end
      4'b10??: begin
        mux_nxt.int_src = adcs_pkg::ADCS_INT_VSS;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mux_r <= '0;
      power_r <= 1'b0;
      sample_r <= 1'b0;
      convert_r <= 1'b0;
    end else begin
      mux_r <= mux_nxt;
      power_r <= cfg_nxt.conv_power_en;
      sample_r <= (state_nxt == adcs_pkg::ADCS_SAMPLE);
      convert_r <= (state_nxt == adcs_pkg::ADCS_CONVERT);
    end
  end

endmodule

/* File: adcs_core_model.sv */
/*
  Behavioural converter core: returns a level for the selected input.
  Assumes the sequencer holds core_mux steady through the convert phase.
*/
`timescale 1ns/100ps
module adcs_core_model (
  // Clock
  input wire logic mclk,
  // Sequencer side
  input wire logic core_power_en,
  input wire logic core_convert,
  input wire adcs_pkg::adcs_mux_t core_mux,
  // Result
  output logic [11:0] core_result
);
  function automatic logic [11:0] level(input adcs_pkg::adcs_mux_t m);
    if (m.ext_connect) begin
      return {8'h3C, m.ext_channel};
    end
    case (m.int_src)
      adcs_pkg::ADCS_INT_VDD: return 12'hFFF;
      adcs_pkg::ADCS_INT_VSS: return 12'h000;
      default: return {1'b1, m.int_src, 6'h00, m.reference};
    endcase
  endfunction

  // Outside conversion the word toggles, so a stale capture cannot pass
  always @(posedge mclk) begin
    if (core_convert && core_power_en) begin
      core_result <= level(core_mux);
    end else begin
      core_result <= ~core_result;
    end
  end
endmodule

/* File: adcs_seq_assertions.sv */
/*
  Port checker of the conversion sequencer.
  Assumes a master that keeps the one-wait handshake and no abort in convert.
*/
`timescale 1ns/100ps
`include "adcs_defines.svh"
module adcs_seq_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Bus
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Core
  input wire logic [11:0] core_result,
  input wire logic core_power_en,
  input wire logic core_sample,
  input wire logic core_convert,
  input wire adcs_pkg::adcs_mux_t core_mux,
  // Interrupt
  input wire logic irq
);
  logic [7:0] c0_r, c1_r, c2_r, c0_nxt, c1_nxt, c2_nxt;
  logic ie_r, ie_nxt, wr;
  logic [11:0] sc_r, cc_r, sc_nxt, cc_nxt;
  assign wr = avs_write && !avs_waitrequest;
  always_comb begin
    c0_nxt = (wr && avs_address == `ADCS_OFS_CTRL0) ? avs_writedata[7:0] : c0_r;
    c1_nxt = (wr && avs_address == `ADCS_OFS_CTRL1) ? avs_writedata[7:0] : c1_r;
    c2_nxt = (wr && avs_address == `ADCS_OFS_CTRL2) ? avs_writedata[7:0] : c2_r;
    ie_nxt = (wr && avs_address == `ADCS_OFS_IRQ_EN) ? avs_writedata[0] : ie_r;
    sc_nxt = core_sample ? sc_r + 12'h001 : 12'h000;
    cc_nxt = core_convert ? cc_r + 12'h001 : 12'h000;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {c0_r, c1_r, c2_r, ie_r, sc_r, cc_r} <= '0;
    end else begin
      {c0_r, c1_r, c2_r, ie_r, sc_r, cc_r} <= {c0_nxt, c1_nxt, c2_nxt, ie_nxt, sc_nxt, cc_nxt};
    end
  end

  function automatic logic ext_code(input logic [3:0] s);
    return s == 4'h0 || s == 4'h4 || s[3:2] == 2'b11;
  endfunction
  function automatic logic [2:0] int_exp(input logic [3:0] s);
    return s[3] ? 3'h7 : (s[2] ? {1'b0, s[1:0]} + 3'h3 : {1'b0, s[1:0]});
  endfunction

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_sample_end;
    $fell(core_sample) && core_convert;
  endsequence
  sequence s_conv_end;
    $fell(core_convert);
  endsequence

  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer not one cycle after request");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_sample_len: assert property (s_sample_end |-> sc_r == (12'h004 << c1_r[2:0]))
    else $error("sample phase length wrong");
  a_conv_len: assert property (s_conv_end |-> cc_r == (12'h00C << c1_r[2:0]))
    else $error("convert phase length wrong");
  a_phase_excl: assert property (!(core_sample && core_convert))
    else $error("sample and convert together");
  a_power_gate: assert property (!core_power_en && !$past(core_power_en) |-> !core_sample && !core_convert)
    else $error("phase active while powered off");
  a_power_follow: assert property (core_power_en == c0_r[`ADCS_C0_POWER])
    else $error("power output does not follow power bit");
  a_mux_sel: assert property ($past(nrst) && $stable(c0_r) && $stable(c1_r) && $stable(c2_r) |->
    core_mux.reference == c2_r[1:0] && (ext_code(c1_r[7:4]) ? core_mux.ext_connect &&
    core_mux.ext_channel == c0_r[7:4] && core_mux.int_src == adcs_pkg::ADCS_INT_NONE :
    !core_mux.ext_connect && core_mux.int_src == int_exp(c1_r[7:4])))
    else $error("input or reference selection wrong");
  a_irq_gate: assert property (irq |-> c2_r[`ADCS_C2_GIE] && ie_r)
    else $error("interrupt without both enables");
  a_irq_at_end: assert property (s_conv_end and (c2_r[`ADCS_C2_GIE] && ie_r) |-> ##[0:2] irq)
    else $error("no interrupt at conversion end");
endmodule

bind adcs_sequencer adcs_seq_assertions u_chk (.mclk(mclk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .core_result(core_result),
  .core_power_en(core_power_en), .core_sample(core_sample),
  .core_convert(core_convert), .core_mux(core_mux), .irq(irq));

/* File: testbench.sv */
/*
  Self-checking bench of the conversion sequencer over Avalon-MM.
  Assumes the behavioural core model on the converter side.
*/
`timescale 1ns/100ps
`include "adcs_defines.svh"
module testbench;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, core_power_en, core_sample, core_convert, irq;
  logic [11:0] core_result, r;
  logic [7:0] hi, lo;
  adcs_pkg::adcs_mux_t core_mux;
  int n_mismatch = 0;
  int checks = 0;
  logic [3:0] src_tab [8] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'hC, 4'h8, 4'h2, 4'h7};

  always #5 mclk = ~mclk;

  adcs_sequencer dut (.mclk(mclk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .core_result(core_result), .core_power_en(core_power_en),
    .core_sample(core_sample), .core_convert(core_convert), .core_mux(core_mux), .irq(irq));
  adcs_core_model u_core (.mclk(mclk), .core_power_en(core_power_en),
    .core_convert(core_convert), .core_mux(core_mux), .core_result(core_result));

  task automatic bus_xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // Only the watchdog ends a wait that never completes
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge mclk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus_xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a);
    bus_xfer(1'b0, a, 32'h0);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Polling over the bus also shows the bus stays usable mid-conversion
  task automatic wait_idle();
    for (int i = 0; i < 1000; i++) begin
      rd(`ADCS_OFS_CTRL0);
      if (q[`ADCS_C0_BUSY] === 1'b0) break;
    end
  endtask
  function automatic logic [11:0] res_exp(input logic [3:0] s, input logic [1:0] rf);
    if (s == 4'h0 || s == 4'h4 || s[3:2] == 2'b11) return {8'h3C, 4'h5};
    if (s[3]) return 12'h000;
    if (s == 4'h1) return 12'hFFF;
    return {1'b1, s[2] ? {1'b0, s[1:0]} + 3'h3 : {1'b0, s[1:0]}, 6'h00, rf};
  endfunction

  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    rd(`ADCS_OFS_CTRL0);
    check(q, 32'h0);
    rd(6'h3C);
    check(q, 32'h0);
    wr(`ADCS_OFS_CTRL2, 32'h2);
    wr(`ADCS_OFS_CTRL0, 32'h52);
    for (int s = 0; s < 16; s++) wr(`ADCS_OFS_CTRL1, 32'(s << 4));
    wr(`ADCS_OFS_IRQ_EN, 32'h1);
    for (int k = 0; k < 8; k++) begin
      wr(`ADCS_OFS_CTRL2, 32'({k[2], 2'b00, k[1:0]}));
      wr(`ADCS_OFS_IRQ_CLR, 32'h1);
      wr(`ADCS_OFS_CTRL1, 32'({src_tab[k], k[0], k[2:0]}));
      wr(`ADCS_OFS_CTRL0, 32'h53);
      wr(`ADCS_OFS_CTRL0, 32'h52);
      rd(`ADCS_OFS_CTRL0);
      check(32'(q[`ADCS_C0_BUSY]), 32'h1);
      wait_idle();
      check(32'(q[`ADCS_C0_BUSY]), 32'h0);
      r = res_exp(src_tab[k], k[1:0]);
      hi = k[0] ? {4'h0, r[11:8]} : r[11:4];
      lo = k[0] ? r[7:0] : {r[3:0], 4'h0};
      rd(`ADCS_OFS_RES_HI);
      check(q, 32'(hi));
      rd(`ADCS_OFS_RES_LO);
      check(q, 32'(lo));
      rd(`ADCS_OFS_IRQ_STAT);
      check(q, 32'h1);
      check(32'(irq), 32'(k >> 2));
    end
    wr(`ADCS_OFS_IRQ_CLR, 32'h1);
    rd(`ADCS_OFS_IRQ_CLR);
    check(q, 32'h0);
    check(32'(irq), 32'h0);
    wr(`ADCS_OFS_CTRL0, 32'h53);
    wr(`ADCS_OFS_CTRL0, 32'h52);
    wr(`ADCS_OFS_CTRL0, 32'h50);
    rd(`ADCS_OFS_CTRL0);
    check(32'(q[`ADCS_C0_BUSY]), 32'h0);
    // A full slow conversion time passes; nothing may complete
    repeat (2100) @(posedge mclk);
    check(32'({core_power_en, core_sample}), 32'h0);
    rd(`ADCS_OFS_IRQ_STAT);
    check(q, 32'h0);
    rd(`ADCS_OFS_RES_LO);
    check(q, 32'(lo));
    wr(`ADCS_OFS_CTRL0, 32'h51);
    wr(`ADCS_OFS_CTRL0, 32'h50);
    rd(`ADCS_OFS_CTRL0);
    check(32'(q[`ADCS_C0_BUSY]), 32'h0);
    give_verdict();
  end

  initial begin
    #300000;
    n_mismatch++;
    give_verdict();
  end
endmodule
